// >>> hdl/spll_map.vh
// Operation
// - frequencies held as 48-bit over 16-bit fraction
// - select direct crystal or internal doubler
// - feedback divider accepts integers 108 through 556
// - reset loads controls from OTP or EEPROM
// - controls writable over host port once loading has finished
// - lock limits derived from configuration automatically
// - loss-of-lock alarm readable and routable to GPIO
`ifndef SPLL_MAP_VH
`define SPLL_MAP_VH

// register byte offsets
`define SPLL_CTRL_OFS 8'h00
`define SPLL_STATUS_OFS 8'h04
`define SPLL_GPIO_OFS 8'h08
`define SPLL_REFM_LO_OFS 8'h0C
`define SPLL_REFM_HI_OFS 8'h10
`define SPLL_REFN_OFS 8'h14

// control fields
`define SPLL_CTRL_DBL_BIT 0
`define SPLL_CTRL_DIV_LSB 16
`define SPLL_CTRL_DIV_MSB 25
`define SPLL_DIV_W 10
`define SPLL_DIV_MIN 10'h06C
`define SPLL_DIV_MAX 10'h22C
`define SPLL_DIV_RESET 10'h0C8
`define SPLL_DBL_RESET 1'b0

// status fields
`define SPLL_STAT_LOL_BIT 0
`define SPLL_STAT_DONE_BIT 1
`define SPLL_STAT_SRC_LSB 2
`define SPLL_STAT_REJ_BIT 4

// gpio routing fields
`define SPLL_GPIO_SEL_BIT 0
`define SPLL_GPIO_VAL_BIT 1

// frequency fraction widths and reset value (25 MHz / 1)
`define SPLL_M_W 48
`define SPLL_N_W 16
`define SPLL_REFM_RESET 48'h0000_017D_7840
`define SPLL_REFN_RESET 16'h0001

// config sources
`define SPLL_SRC_NONE 2'h0
`define SPLL_SRC_OTP 2'h1
`define SPLL_SRC_EE 2'h2

// control voltage monitor
`define SPLL_VC_W 8
`define SPLL_VC_MARGIN 8'h20

`endif

// >>> hdl/spll_lock_mon.v
`timescale 1ns/1ps
`include "spll_map.vh"

module spll_lock_mon #(
	parameter VC_W = `SPLL_VC_W
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// configuration
	input wire doubler_en,
	input wire [`SPLL_DIV_W-1:0] fb_div,
	// synchronised control voltage code
	input wire [VC_W-1:0] vc_code,
	// result
	output reg loss_of_lock
);
	// window centre scales with the divider, shifted down when doubled
	wire [VC_W-1:0] centre;
	wire [VC_W:0] lo_raw;
	wire [VC_W:0] hi_raw;
	wire [VC_W-1:0] lim_lo;
	wire [VC_W-1:0] lim_hi;

	assign centre = doubler_en ? fb_div[VC_W+1:2] - {1'b0, fb_div[VC_W+1:3]} :
		fb_div[VC_W+1:2];
	assign lo_raw = {1'b0, centre} - {1'b0, `SPLL_VC_MARGIN};
	assign hi_raw = {1'b0, centre} + {1'b0, `SPLL_VC_MARGIN};
	// clamp instead of wrapping, so extreme dividers still get a usable window
	assign lim_lo = lo_raw[VC_W] ? {VC_W{1'b0}} : lo_raw[VC_W-1:0];
	assign lim_hi = hi_raw[VC_W] ? {VC_W{1'b1}} : hi_raw[VC_W-1:0];

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			loss_of_lock <= 1'b1;
		end else begin
			// live level: follows the window every cycle
			loss_of_lock <= (vc_code < lim_lo) || (vc_code > lim_hi);
		end
	end
endmodule

// >>> hdl/spll_ctrl.v
`timescale 1ns/1ps
`include "spll_map.vh"

module spll_ctrl (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// otp source
	input wire otp_en,
	input wire otp_valid,
	input wire otp_doubler,
	input wire [`SPLL_DIV_W-1:0] otp_fb_div,
	// eeprom loader
	input wire ee_en,
	output reg ee_req,
	input wire ee_done,
	input wire ee_valid,
	input wire ee_doubler,
	input wire [`SPLL_DIV_W-1:0] ee_fb_div,
	// analog pll side
	output reg pll_doubler_en,
	output reg [`SPLL_DIV_W-1:0] pll_fb_div,
	input wire [`SPLL_VC_W-1:0] pll_vc_code,
	// status outputs
	output reg lol_alarm,
	output reg gpio_status
);
	localparam ST_START = 4'b0001;
	localparam ST_EE_REQ = 4'b0010;
	localparam ST_EE_WAIT = 4'b0100;
	localparam ST_RUN = 4'b1000;

	reg [3:0] state;
	reg [3:0] next_state;
	reg [1:0] cfg_src;
	reg div_reject;
	reg gpio_sel;
	reg gpio_val;
	reg [`SPLL_M_W-1:0] ref_m;
	reg [`SPLL_N_W-1:0] ref_n;
	reg [`SPLL_VC_W-1:0] vc_meta;
	reg [`SPLL_VC_W-1:0] vc_sync;
	wire lol_live;
	wire setup;
	wire wr_take;
	wire div_ok;
	wire [`SPLL_DIV_W-1:0] wr_div;
	reg addr_ok;
	reg [31:0] next_rdata;

	assign setup = psel && !penable;
	assign wr_take = psel && penable && pready && pwrite && !pslverr;
	assign wr_div = pwdata[`SPLL_CTRL_DIV_MSB:`SPLL_CTRL_DIV_LSB];
	assign div_ok = (wr_div >= `SPLL_DIV_MIN) && (wr_div <= `SPLL_DIV_MAX);

	// analog code is asynchronous; a code settling over many cycles makes
	// multi-bit skew harmless
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			vc_meta <= {`SPLL_VC_W{1'b0}};
			vc_sync <= {`SPLL_VC_W{1'b0}};
		end else begin
			vc_meta <= pll_vc_code;
			vc_sync <= vc_meta;
		end
	end

	spll_lock_mon #(
		.VC_W(`SPLL_VC_W)
	) u_lock_mon (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.doubler_en(pll_doubler_en),
		.fb_div(pll_fb_div),
		.vc_code(vc_sync),
		.loss_of_lock(lol_live)
	);

	// configuration load sequence
	always @* begin
		next_state = state;
		case (state)
			ST_START: begin
				if (otp_en && otp_valid) begin
					next_state = ST_RUN;
				end else if (ee_en) begin
					next_state = ST_EE_REQ;
				end else begin
					next_state = ST_RUN;
				end
			end
			ST_EE_REQ: begin
				next_state = ST_EE_WAIT;
			end
			ST_EE_WAIT: begin
				if (ee_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_START;
			end
		endcase
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_START;
			ee_req <= 1'b0;
			cfg_src <= `SPLL_SRC_NONE;
			pll_doubler_en <= `SPLL_DBL_RESET;
			pll_fb_div <= `SPLL_DIV_RESET;
			div_reject <= 1'b0;
		end else begin
			state <= next_state;
			ee_req <= (next_state == ST_EE_REQ) || (next_state == ST_EE_WAIT);
			if (state == ST_START && otp_en && otp_valid) begin
				pll_doubler_en <= otp_doubler;
				pll_fb_div <= otp_fb_div;
				cfg_src <= `SPLL_SRC_OTP;
			end else if (state == ST_EE_WAIT && ee_done && ee_valid) begin
				// contents without a valid mark leave the defaults in place
				pll_doubler_en <= ee_doubler;
				pll_fb_div <= ee_fb_div;
				cfg_src <= `SPLL_SRC_EE;
			end else if (state == ST_RUN && wr_take && paddr == `SPLL_CTRL_OFS) begin
				// host reconfiguration only once loading has finished
				if (div_ok) begin
					pll_doubler_en <= pwdata[`SPLL_CTRL_DBL_BIT];
					pll_fb_div <= wr_div;
					div_reject <= 1'b0;
				end else begin
					div_reject <= 1'b1;
				end
			end
		end
	end

	// software registers
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gpio_sel <= 1'b0;
			gpio_val <= 1'b0;
			ref_m <= `SPLL_REFM_RESET;
			ref_n <= `SPLL_REFN_RESET;
		end else if (wr_take) begin
			case (paddr)
				`SPLL_GPIO_OFS: begin
					gpio_sel <= pwdata[`SPLL_GPIO_SEL_BIT];
					gpio_val <= pwdata[`SPLL_GPIO_VAL_BIT];
				end
				`SPLL_REFM_LO_OFS: begin
					ref_m[31:0] <= pwdata;
				end
				`SPLL_REFM_HI_OFS: begin
					ref_m[`SPLL_M_W-1:32] <= pwdata[`SPLL_M_W-33:0];
				end
				`SPLL_REFN_OFS: begin
					ref_n <= pwdata[`SPLL_N_W-1:0];
				end
				default: begin
					ref_n <= ref_n;
				end
			endcase
		end
	end

	// read mux and address decode
	always @* begin
		next_rdata = 32'h0000_0000;
		addr_ok = 1'b1;
		case (paddr)
			`SPLL_CTRL_OFS: begin
				next_rdata[`SPLL_CTRL_DBL_BIT] = pll_doubler_en;
				next_rdata[`SPLL_CTRL_DIV_MSB:`SPLL_CTRL_DIV_LSB] = pll_fb_div;
			end
			`SPLL_STATUS_OFS: begin
				next_rdata[`SPLL_STAT_LOL_BIT] = lol_alarm;
				next_rdata[`SPLL_STAT_DONE_BIT] = (state == ST_RUN);
				next_rdata[`SPLL_STAT_SRC_LSB+1:`SPLL_STAT_SRC_LSB] = cfg_src;
				next_rdata[`SPLL_STAT_REJ_BIT] = div_reject;
			end
			`SPLL_GPIO_OFS: begin
				next_rdata[`SPLL_GPIO_SEL_BIT] = gpio_sel;
				next_rdata[`SPLL_GPIO_VAL_BIT] = gpio_val;
			end
			`SPLL_REFM_LO_OFS: begin
				next_rdata = ref_m[31:0];
			end
			`SPLL_REFM_HI_OFS: begin
				next_rdata[`SPLL_M_W-33:0] = ref_m[`SPLL_M_W-1:32];
			end
			`SPLL_REFN_OFS: begin
				next_rdata[`SPLL_N_W-1:0] = ref_n;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// zero-wait answer: data and ready are registered in the setup cycle
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !addr_ok;
			if (setup && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	// alarm and gpio source
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lol_alarm <= 1'b1;
			gpio_status <= 1'b0;
		end else begin
			lol_alarm <= lol_live;
			gpio_status <= gpio_sel ? lol_live : gpio_val;
		end
	end
endmodule

// >>> tb/spll_ctrl_props.sv
`timescale 1ns/1ps
module spll_ctrl_props (
	// watched ports
	input wire clk_sys,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire otp_en,
	input wire ee_req,
	input wire ee_done,
	input wire pll_doubler_en,
	input wire [9:0] pll_fb_div,
	input wire [7:0] pll_vc_code,
	input wire lol_alarm
);
	wire [9:0] c = pll_doubler_en ? (pll_fb_div >> 2) - (pll_fb_div >> 3) : pll_fb_div >> 2;
	wire w = pll_vc_code + 10'h020 >= c && pll_vc_code <= c + 10'h020;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_RDY: assert property (psel && !penable |=> pready)
		else $error("no ready");
	AST_RDY1: assert property (pready |=> !pready)
		else $error("long ready");
	AST_MAP: assert property (psel && !penable && paddr > 8'h14 |=> pready && pslverr)
		else $error("bad map");
	AST_DIV: assert property (pll_fb_div >= 10'h06C && pll_fb_div <= 10'h22C)
		else $error("bad divider");
	AST_EE: assert property (ee_req && ee_done |=> !ee_req)
		else $error("req held");
	AST_CHG: assert property ($changed(pll_fb_div) |->
		$past(psel && penable && pwrite || ee_done || otp_en))
		else $error("divider moved");
	AST_LOCK: assert property (w [*6] |-> !lol_alarm)
		else $error("false alarm");
	AST_LOL: assert property (!w [*6] |-> lol_alarm)
		else $error("no alarm");
endmodule
bind spll_ctrl spll_ctrl_props i_spll_ctrl_props (.*);

// >>> tb/spll_ee_model.sv
`timescale 1ns/1ps
module spll_ee_model (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// loader
	input wire ee_req,
	output reg ee_done,
	output wire ee_valid,
	output wire ee_doubler,
	output wire [9:0] ee_fb_div
);
	reg [3:0] n;
	// lines flicker when not qualified by done
	assign ee_valid = ee_done | n[0];
	assign ee_doubler = ee_done | n[0];
	assign ee_fb_div = ee_done ? 10'h1F4 : {10{n[0]}} ^ 10'h1F4;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			n <= 4'h0;
			ee_done <= 1'b0;
		end else begin
			n <= ee_req ? n + 4'h1 : {3'h0, ~n[0]};
			ee_done <= ee_req && n == 4'h5;
		end
	end
endmodule

// >>> tb/tb_spll_ctrl.sv
`timescale 1ns/1ps
module tb_spll_ctrl;
	reg clk_sys = 1'b0;
	reg rst_n = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0000_0000;
	reg otp_en = 1'b0;
	reg otp_valid = 1'b1;
	reg ee_en = 1'b1;
	reg [7:0] pll_vc_code = 8'h32;
	wire [31:0] prdata;
	wire pready, pslverr, ee_req, ee_done, ee_valid, ee_doubler, pll_doubler_en;
	wire lol_alarm, gpio_status;
	wire [9:0] ee_fb_div, pll_fb_div;
	reg [31:0] rd;
	reg er;
	integer fails = 0;
	integer n_checks = 0;
	integer i, j;
	always #5 clk_sys = ~clk_sys;
	spll_ctrl i_spll_ctrl (.*, .otp_valid(otp_valid), .otp_doubler(1'b0), .otp_fb_div(10'h1B0),
		.ee_en(ee_en));
	spll_ee_model i_spll_ee_model (.*);
	task results;
		begin
			$display("checks %0d fails %0d", n_checks, fails);
			if (fails == 0 && n_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	task xfer(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge clk_sys);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk_sys);
			penable <= 1'b1;
			@(posedge clk_sys);
			for (i = 0; pready !== 1'b1 && i < 20; i = i + 1)
				@(posedge clk_sys);
			if (i == 20) begin
				fails = fails + 1;
				results;
			end
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task tdiv(input [10:0] v, input [10:0] e, input r);
		begin
			xfer(1'b1, 8'h00, {6'h00, v[9:0], 15'h0000, v[10]});
			// new control value settles after the access edge
			@(posedge clk_sys);
			chk({pll_doubler_en, pll_fb_div}, e);
			xfer(1'b0, 8'h04, 32'h0000_0000);
			chk(rd[4], r);
		end
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd = 32'h0000_0000;
		for (j = 0; j < 30 && rd[1] !== 1'b1; j = j + 1)
			xfer(1'b0, 8'h04, 32'h0000_0000);
		chk(rd[4:1], 4'h5);
		xfer(1'b0, 8'h00, 32'h0000_0000);
		chk(rd, 32'h01F4_0001);
		xfer(1'b0, 8'h0C, 32'h0000_0000);
		chk(rd, 32'h017D_7840);
		xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
		xfer(1'b0, 8'h10, 32'h0000_0000);
		chk(rd, 32'h0000_FFFF);
		xfer(1'b0, 8'h14, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		tdiv(11'h06C, 11'h06C, 1'b0);
		tdiv(11'h62D, 11'h06C, 1'b1);
		tdiv(11'h62C, 11'h62C, 1'b0);
		tdiv(11'h06B, 11'h62C, 1'b1);
		// doubled reference times 272 lands inside the tuning range
		tdiv(11'h510, 11'h510, 1'b0);
		xfer(1'b0, 8'h18, 32'h0000_0000);
		chk(er, 1'b1);
		repeat (8) @(posedge clk_sys);
		chk(lol_alarm, 1'b0);
		pll_vc_code <= 8'hC8;
		xfer(1'b1, 8'h08, 32'h0000_0001);
		repeat (8) @(posedge clk_sys);
		chk(gpio_status, 1'b1);
		xfer(1'b0, 8'h04, 32'h0000_0000);
		xfer(1'b0, 8'h04, 32'h0000_0000);
		chk(rd[0], 1'b1);
		pll_vc_code <= 8'h32;
		repeat (8) @(posedge clk_sys);
		chk({lol_alarm, gpio_status}, 2'h0);
		xfer(1'b1, 8'h08, 32'h0000_0002);
		// register written on the access edge; one edge for the registered pin, one spare
		repeat (2) @(posedge clk_sys);
		chk(gpio_status, 1'b1);
		rst_n <= 1'b0;
		otp_en <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		xfer(1'b0, 8'h04, 32'h0000_0000);
		chk({rd[3:1], pll_fb_div}, 13'h0DB0);
		// no valid source: defaults stay, source reads none
		rst_n <= 1'b0;
		otp_valid <= 1'b0;
		ee_en <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		xfer(1'b0, 8'h04, 32'h0000_0000);
		chk({rd[3:1], pll_fb_div}, 13'h04C8);
		results;
	end
endmodule
